// ### hw/frame_checksum_params.svh
`ifndef FRAME_CHECKSUM_PARAMS_SVH
`define FRAME_CHECKSUM_PARAMS_SVH

// Register indices; byte address is four times the index.
`define CHECKER_CONTROL_INDEX 8'h2C
`define CHECKER_FRAME_COUNT_INDEX 8'h2D
`define CHECKSUM_RESULT_FIRST_BYTE_INDEX 8'h2E
`define CHECKSUM_RESULT_SECOND_BYTE_INDEX 8'h2F

// Control register fields.
`define CONTROL_ENABLE_BIT 7
`define CONTROL_BLOCK_RESET_BIT 6
`define CONTROL_SELECT_HIGH 5
`define CONTROL_SELECT_LOW 4

// Reset values and limits.
`define CONTROL_RESET_VALUE 8'h00
`define FRAME_COUNT_RESET_VALUE 8'h07
`define FRAME_COUNT_MIN 8'h01
`define FRAME_COUNT_MAX 8'hFE
`define RESULT_RESET_VALUE 16'h0000

// Checksum generator: x^16 + x^12 + x^5 + 1, start value all ones.
`define CHECKSUM_POLY 16'h1021
`define CHECKSUM_INIT 16'hFFFF

`endif

// ### hw/frame_checksum_pkg.sv
package frame_checksum_pkg;

  typedef enum logic [1:0]
  {
    idle_state = 2'b00,
    wait_frame_state = 2'b01,
    accumulate_state = 2'b11,
    done_state = 2'b10
  } run_state_type;

  typedef struct packed
  {
    logic frame_start;
    logic pixel_valid;
    logic from_digital;
    logic [7:0] green;
    logic [7:0] blue;
    logic [7:0] red;
  } pixel_type;

  typedef struct packed
  {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_request_type;

endpackage

// ### hw/video_frame_checksum_checker.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "frame_checksum_params.svh"

module video_frame_checksum_checker
#(
  parameter int channels = 3,
  parameter int pixel_width = 8
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire frame_checksum_pkg::pixel_type pixel_in,
  input wire frame_checksum_pkg::apb_request_type apb_in,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic run_done
);
  import frame_checksum_pkg::*;

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  logic [7:0] checker_control;
  logic [7:0] checker_frame_count;
  logic [9:0] word_index;
  logic access;
  logic mapped;
  logic [7:0] next_read_byte;
  logic [15:0] selected_result;

  assign word_index = apb_in.paddr[11:2];
  assign access = apb_in.psel && apb_in.penable && !pready;
  assign mapped = (apb_in.paddr[1:0] == 2'b00)
    && (word_index[9:8] == 2'b00)
    && (word_index[7:2] == 6'(`CHECKER_CONTROL_INDEX >> 2));

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      checker_control <= `CONTROL_RESET_VALUE;
      checker_frame_count <= `FRAME_COUNT_RESET_VALUE;
    end
    else if (access && apb_in.pwrite && mapped)
    begin
      if (word_index[7:0] == `CHECKER_CONTROL_INDEX)
      begin
        checker_control <= {apb_in.pwdata[7:4], 4'h0};
      end
      else if (word_index[7:0] == `CHECKER_FRAME_COUNT_INDEX)
      begin
        checker_frame_count <= apb_in.pwdata[7:0];
      end
    end
  end

  always_comb
  begin
    next_read_byte = 8'h00;
    case (word_index[7:0])
      `CHECKER_CONTROL_INDEX: next_read_byte = checker_control;
      `CHECKER_FRAME_COUNT_INDEX: next_read_byte = checker_frame_count;
      `CHECKSUM_RESULT_FIRST_BYTE_INDEX: next_read_byte = selected_result[15:8];
      `CHECKSUM_RESULT_SECOND_BYTE_INDEX: next_read_byte = selected_result[7:0];
      default: next_read_byte = 8'h00;
    endcase
  end

  // Every access completes one cycle into the access phase; the answer is a register.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= access;
      pslverr <= access && !mapped;
      if (access && !apb_in.pwrite)
      begin
        prdata <= mapped ? {24'h00_0000, next_read_byte} : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  logic enable;
  logic block_reset;
  logic count_legal;
  logic take_pixel;
  run_state_type run_state;
  logic [7:0] frames_seen;

  assign enable = checker_control[`CONTROL_ENABLE_BIT];
  assign block_reset = checker_control[`CONTROL_BLOCK_RESET_BIT];
  assign count_legal = (checker_frame_count >= `FRAME_COUNT_MIN)
    && (checker_frame_count <= `FRAME_COUNT_MAX);
  // Digitizer pixels carry converter noise, so only digital-path pixels count.
  assign take_pixel = pixel_in.pixel_valid && pixel_in.from_digital;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      run_state <= idle_state;
      frames_seen <= 8'h00;
    end
    else if (block_reset)
    begin
      run_state <= wait_frame_state;
      frames_seen <= 8'h00;
    end
    else
    begin
      case (run_state)
        idle_state:
        begin
          frames_seen <= 8'h00;
        end
        wait_frame_state:
        begin
          if (enable && count_legal && pixel_in.frame_start)
          begin
            run_state <= accumulate_state;
            frames_seen <= 8'h00;
          end
        end
        accumulate_state:
        begin
          if (!enable)
          begin
            run_state <= idle_state;
          end
          else if (pixel_in.frame_start)
          begin
            if (frames_seen + 8'h01 == checker_frame_count)
            begin
              run_state <= done_state;
            end
            frames_seen <= frames_seen + 8'h01;
          end
        end
        done_state:
        begin
          frames_seen <= frames_seen;
        end
        default:
        begin
          run_state <= idle_state;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      run_done <= 1'b0;
    end
    else
    begin
      run_done <= (run_state == done_state);
    end
  end

  // ----------------------------------------------------------------------
  // Checksum accumulators
  // ----------------------------------------------------------------------
  logic [pixel_width-1:0] channel_data [channels];
  logic [15:0] accumulator [channels];
  logic [15:0] result [channels];
  logic accumulate_now;
  logic start_run;
  logic finish_run;

  assign channel_data[0] = pixel_in.green;
  assign channel_data[1] = pixel_in.blue;
  assign channel_data[2] = pixel_in.red;

  // The frame-start pixel of the first frame is the first pixel counted.
  assign start_run = (run_state == wait_frame_state) && !block_reset && enable
    && count_legal && pixel_in.frame_start;
  assign accumulate_now = take_pixel && !block_reset && (start_run
    || ((run_state == accumulate_state) && enable
    && !(pixel_in.frame_start && (frames_seen + 8'h01 == checker_frame_count))));
  assign finish_run = (run_state == accumulate_state) && !block_reset && enable
    && pixel_in.frame_start && (frames_seen + 8'h01 == checker_frame_count);

  function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                           input logic [pixel_width-1:0] data);
    logic [15:0] value;
    value = crc;
    for (int i = pixel_width - 1; i >= 0; i--)
    begin
      if (value[15] ^ data[i])
      begin
        value = {value[14:0], 1'b0} ^ `CHECKSUM_POLY;
      end
      else
      begin
        value = {value[14:0], 1'b0};
      end
    end
    return value;
  endfunction

  genvar ch;
  generate
    for (ch = 0; ch < channels; ch++)
    begin : channel_gen
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
        begin
          accumulator[ch] <= `CHECKSUM_INIT;
          result[ch] <= `RESULT_RESET_VALUE;
        end
        else if (block_reset)
        begin
          accumulator[ch] <= `CHECKSUM_INIT;
        end
        else if (start_run)
        begin
          accumulator[ch] <= take_pixel ? crc_step(`CHECKSUM_INIT, channel_data[ch])
            : `CHECKSUM_INIT;
        end
        else if (accumulate_now)
        begin
          accumulator[ch] <= crc_step(accumulator[ch], channel_data[ch]);
        end
        else if (finish_run)
        begin
          result[ch] <= accumulator[ch];
        end
      end
    end
  endgenerate

  always_comb
  begin
    case (checker_control[`CONTROL_SELECT_HIGH:`CONTROL_SELECT_LOW])
      2'b00: selected_result = result[0];
      2'b01: selected_result = result[1];
      2'b10: selected_result = result[2];
      default: selected_result = 16'h0000;
    endcase
  end

endmodule
`default_nettype wire

// ### verif/frame_checksum_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module frame_checksum_asserts
(
  input wire logic mclk,
  input wire logic rstn,
  input wire frame_checksum_pkg::pixel_type pixel_in,
  input wire frame_checksum_pkg::apb_request_type apb_in,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic run_done
);
  import frame_checksum_pkg::*;
  logic acc;
  logic hit;
  logic blk;
  assign acc = apb_in.psel && apb_in.penable;
  assign hit = apb_in.paddr inside {12'hB0, 12'hB4, 12'hB8, 12'hBC};
  assign blk = acc && !pready && apb_in.pwrite && apb_in.paddr == 12'hB0 && apb_in.pwdata[6];
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  chk_ready_wait: assert property (acc && !pready |=> pready)
    else $error("ready late");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  chk_error_decode: assert property (pready |-> pslverr == !hit)
    else $error("error flag wrong");
  chk_read_width: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data set");
  chk_control_low: assert property (pready && !apb_in.pwrite && apb_in.paddr == 12'hB0
    |-> prdata[3:0] == 4'h0)
    else $error("control low bits set");
  chk_done_cause: assert property ($rose(run_done)
    |-> $past(pixel_in.frame_start) || $past(pixel_in.frame_start, 2))
    else $error("done without frame start");
  chk_done_holds: assert property (run_done && !blk && !$past(blk) && !$past(blk, 2) |=> run_done)
    else $error("done dropped");
  chk_reset_clears: assert property (blk |-> ##[1:3] !run_done)
    else $error("block reset ignored");
  cover property ($rose(run_done));
  cover property (pready && pslverr);
  cover property (blk);
endmodule
`default_nettype wire

// ### verif/pixel_source.sv
`timescale 1ns/1ps
`default_nettype none
module pixel_source
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] seed,
  input wire logic flip,
  input wire logic slow,
  output var frame_checksum_pkg::pixel_type pix
);
  import frame_checksum_pkg::*;
  logic [4:0] k;
  logic hold;
  logic on;
  function automatic logic [7:0] px(input logic [4:0] i, input int c);
    return seed + 8'(i) * 8'h11 + 8'(c) * 8'h40 ^ 8'(flip && i == 5'd3 && c == 0);
  endfunction
  // Blanking data is inverted each cycle so a stray sample cannot match by luck.
  assign on = !hold && k < 5'd16;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      k <= 5'd0;
      hold <= 1'b0;
      pix <= '0;
    end
    else
    begin
      hold <= slow && !hold;
      if (!hold)
        k <= (k == 5'd19) ? 5'd0 : k + 5'd1;
      pix.frame_start <= !hold && k == 5'd0;
      pix.pixel_valid <= on;
      pix.from_digital <= k != 5'd9;
      pix.green <= on ? px(k, 0) : ~pix.green;
      pix.blue <= on ? px(k, 1) : ~pix.blue;
      pix.red <= on ? px(k, 2) : ~pix.red;
    end
  end
endmodule
`default_nettype wire

// ### verif/video_frame_checksum_checker_tb.sv
`timescale 1ns/1ps
`default_nettype none
module video_frame_checksum_checker_tb;
  import frame_checksum_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  pixel_type pix;
  apb_request_type apb_in = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic run_done;
  logic [7:0] seed = 8'h00;
  logic flip = 1'b0;
  logic slow = 1'b0;
  logic [31:0] rd;
  logic err;
  logic [31:0] rng = 32'h0F90;
  logic [7:0] m;
  int n_errors = 0;
  int checks = 0;
  always #5 mclk = ~mclk;
  pixel_source src_i (.mclk(mclk), .rstn(rstn), .seed(seed), .flip(flip), .slow(slow),
    .pix(pix));
  video_frame_checksum_checker video_frame_checksum_checker_i (.mclk(mclk), .rstn(rstn),
    .pixel_in(pix), .apb_in(apb_in), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_done(run_done));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [7:0] pixel_value(input logic [4:0] i, input int c);
    return seed + 8'(i) * 8'h11 + 8'(c) * 8'h40 ^ 8'(flip && i == 5'd3 && c == 0);
  endfunction
  function automatic logic [15:0] crc(input int n, input int c);
    logic [15:0] r;
    logic [7:0] b;
    r = 16'hFFFF;
    for (int f = 0; f < n * 16; f++)
      if (f % 16 != 9)
      begin
        b = pixel_value(5'(f % 16), c);
        for (int j = 7; j >= 0; j--)
          r = {r[14:0], 1'b0} ^ ((r[15] ^ b[j]) ? 16'h1021 : 16'h0000);
      end
    return r;
  endfunction
  // ----------------------------------------
  // Bus master: holds the request until ready.
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int i;
    apb_in <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge mclk);
    apb_in.penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge mclk);
      i++;
    end
    while (pready !== 1'b1 && i < 9);
    rd = prdata;
    err = pslverr;
    apb_in <= '0;
    @(posedge mclk);
    if (i == 9)
    begin
      check(32'h0, 32'h1);
      end_of_test();
    end
  endtask
  task automatic run(input logic [7:0] n);
    int i;
    apb(1'b1, 12'hB4, n);
    apb(1'b1, 12'hB0, 8'h80);
    apb(1'b1, 12'hB0, 8'hC0);
    apb(1'b1, 12'hB0, 8'h80);
    i = 0;
    // The long software wait is replaced by watching for the end of the run.
    while (run_done !== 1'b1 && i < 20000)
    begin
      @(posedge mclk);
      i++;
    end
    check(32'(run_done), 32'h1);
    if (run_done !== 1'b1)
      end_of_test();
    for (int c = 0; c < 3; c++)
    begin
      apb(1'b1, 12'hB0, 8'h80 | 8'(c << 4));
      apb(1'b0, 12'hB8, 8'h00);
      check(rd, 32'(crc(n, c) >> 8));
      apb(1'b0, 12'hBC, 8'h00);
      check(rd, 32'(crc(n, c) & 16'h00FF));
    end
    $display("run of %0d frames done", n);
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    for (int j = 0; j < 4; j++)
    begin
      apb(1'b0, 12'hB0 + 12'(4 * j), 8'h00);
      check(rd, j == 1 ? 32'h7 : 32'h0);
    end
    apb(1'b0, 12'hC0, 8'h00);
    check({rd[30:0], err}, 32'h1);
    apb(1'b1, 12'hB8, 8'h5A);
    apb(1'b0, 12'hB8, 8'h00);
    check(rd, 32'h0);
    $display("reset values done");
    run(8'h01);
    seed <= 8'(xs());
    slow <= 1'b1;
    m = 8'(xs() % 40 + 1);
    for (int t = 0; t < 3; t++)
    begin
      flip <= t == 1;
      run(m);
    end
    slow <= 1'b0;
    run(8'hFE);
    apb(1'b1, 12'hB0, 8'hB0);
    apb(1'b0, 12'hB8, 8'h00);
    check(rd, 32'h0);
    apb(1'b1, 12'hB4, 8'h00);
    apb(1'b1, 12'hB0, 8'hC0);
    apb(1'b1, 12'hB0, 8'h80);
    repeat (100) @(posedge mclk);
    check(32'(run_done), 32'h0);
    apb(1'b0, 12'hB0, 8'h00);
    check(rd, 32'h80);
    apb(1'b0, 12'hB8, 8'h00);
    check(rd, 32'(crc(254, 0) >> 8));
    $display("reserved settings done");
    end_of_test();
  end
endmodule
bind video_frame_checksum_checker frame_checksum_asserts frame_checksum_asserts_i (.mclk(mclk),
  .rstn(rstn), .pixel_in(pixel_in), .apb_in(apb_in), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .run_done(run_done));
`default_nettype wire
